// File: psep_top.sv
// Port 6, 7 and 8 pin logic with AXI4-Lite register access
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Functional notes
// - With bus release on, port 6 bit 2 drives acknowledge; else direction picks.
// - With bus release on, port 6 bit 1 is bus request input; else direction picks.
// - Port 6 bit 0 is wait input if mode-hi set or wait field not all ones.
// - Port 7 is eight input-only pins, never driven, no direction register.
// - Port 7 read always returns current pin levels; no fixed reset value.
// - Port 8 has five two-way pins, bits 4 to 0, same in all modes.
// - Port 8 direction bits 4..1 give chip selects 0..3; bit 0 plain output.
// - Port 8 pin with direction zero is an input, driver off.
// - Port 8 direction register is write-only and reads all ones.
// - Port 8 direction resets to f0 on reset and hardware standby; holds otherwise.
// - Port 8 read gives latch for output pins, pin level for input pins.
// - Port 8 latch bits 7..5 ignore writes and read one.
// - Port 8 latch resets to e0 on reset and hardware standby; holds otherwise.
// - Port 6 plain pin drives when direction is one, inputs when zero.
// - Port 6 read gives latch for output pins, pin level for input pins.
module psep_top
  import psep_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          hw_standby,
  input  wire logic          sw_standby,
  input  wire logic          awvalid,
  output      logic          awready,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          wvalid,
  output      logic          wready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  output      logic          bvalid,
  input  wire logic          bready,
  output      logic [1:0]    bresp,
  input  wire logic          arvalid,
  output      logic          arready,
  input  wire logic [AW-1:0] araddr,
  output      logic          rvalid,
  input  wire logic          rready,
  output      logic [31:0]   rdata,
  output      logic [1:0]    rresp,
  input  wire logic [2:0]    p6_in,
  output      psep_p6_pad_s  p6_pad,
  input  wire logic [7:0]    p7_in,
  input  wire logic [4:0]    p8_in,
  output      psep_p8_pad_s  p8_pad,
  input  wire logic          bus_grant_ack_n,
  input  wire logic [3:0]    chip_select_n,
  output      psep_ctl_s     ctl
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0]     p6_dir_q, p6_dir_d;
  logic [7:0]     p6_lat_q, p6_lat_d;
  logic [7:0]     p8_dir_q, p8_dir_d;
  logic [7:0]     p8_lat_q, p8_lat_d;
  logic [CFG_W-1:0] cfg_q, cfg_d;

  logic           awv_q, awv_d;
  logic [15:0]    widx_q, widx_d;
  logic           wv_q, wv_d;
  logic [31:0]    wdat_q, wdat_d;
  logic           wstb_q, wstb_d;
  logic           awready_q, awready_d;
  logic           wready_q, wready_d;
  logic           bvalid_q, bvalid_d;
  logic [1:0]     bresp_q, bresp_d;
  logic           arready_q, arready_d;
  logic           rvalid_q, rvalid_d;
  logic [31:0]    rdata_q, rdata_d;
  logic [1:0]     rresp_q, rresp_d;

  psep_p6_pad_s   p6_pad_q, p6_pad_d;
  psep_p8_pad_s   p8_pad_q, p8_pad_d;
  psep_ctl_s      ctl_q, ctl_d;

  logic           do_wr;
  logic           ar_hs;
  logic [15:0]    ridx;
  logic           bre;
  logic           wait_sel;
  logic [7:0]     p6_rd;
  logic [7:0]     p8_rd;
  logic           hold;

  // Software standby blocks register writes: port and config registers hold
  assign hold     = sw_standby;
  assign bre      = cfg_q[CFG_BUS_RELEASE_ENABLE];
  assign wait_sel = cfg_q[CFG_WMS] |
                    (cfg_q[CFG_WCE_LSB +: 8] != WCE_ALL);
  assign do_wr    = awv_q & wv_q & ~bvalid_q;
  assign ar_hs    = arvalid & arready_q;
  assign ridx     = araddr[AW-1:2];

  // ------------------------------------------------------------
  // Read views of the ports
  // ------------------------------------------------------------
  assign p6_rd = {P6_RSV[7], p6_lat_q[6:3],
                  (p6_dir_q[2:0] & p6_lat_q[2:0]) |
                  (~p6_dir_q[2:0] & p6_in)};
  assign p8_rd = P8_RSV |
                 {3'h0, (p8_dir_q[4:0] & p8_lat_q[4:0]) |
                        (~p8_dir_q[4:0] & p8_in)};

  // ------------------------------------------------------------
  // Write channel
  // ------------------------------------------------------------
  always_comb begin
    awv_d     = (awv_q & ~do_wr) | (awvalid & awready_q);
    widx_d    = (awvalid & awready_q) ? awaddr[AW-1:2] : widx_q;
    wv_d      = (wv_q & ~do_wr) | (wvalid & wready_q);
    wdat_d    = (wvalid & wready_q) ? wdata : wdat_q;
    wstb_d    = (wvalid & wready_q) ? wstrb[0] : wstb_q;
    awready_d = ~awv_d;
    wready_d  = ~wv_d;
    bvalid_d  = (bvalid_q & ~bready) | do_wr;
    bresp_d   = bresp_q;
    if (do_wr) begin
      unique case (widx_q)
        IDX_CFG, IDX_P6_DIR, IDX_P6_LAT,
        IDX_P8_DIR, IDX_P7_PIN, IDX_P8_LAT: bresp_d = RESP_OKAY;
        default:                             bresp_d = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awv_q     <= 1'b0;
      widx_q    <= 16'h0000;
      wv_q      <= 1'b0;
      wdat_q    <= 32'h0000_0000;
      wstb_q    <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      awv_q     <= awv_d;
      widx_q    <= widx_d;
      wv_q      <= wv_d;
      wdat_q    <= wdat_d;
      wstb_q    <= wstb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // ------------------------------------------------------------
  // Port registers
  // ------------------------------------------------------------
  always_comb begin
    p6_dir_d = p6_dir_q;
    p6_lat_d = p6_lat_q;
    p8_dir_d = p8_dir_q;
    p8_lat_d = p8_lat_q;
    cfg_d    = cfg_q;
    if (do_wr && wstb_q && !hold) begin
      unique case (widx_q)
        IDX_CFG:    cfg_d    = wdat_q[CFG_W-1:0];
        IDX_P6_DIR: p6_dir_d = (wdat_q[7:0] & P6_DIR_WM) | P6_RSV;
        IDX_P6_LAT: p6_lat_d = (wdat_q[7:0] & P6_LAT_WM) | P6_RSV;
        IDX_P8_DIR: p8_dir_d = (wdat_q[7:0] & P8_WM) | P8_RSV;
        IDX_P8_LAT: p8_lat_d = (wdat_q[7:0] & P8_WM) | P8_RSV;
        default:    cfg_d    = cfg_q;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      p6_dir_q <= P6_DIR_RST;
      p6_lat_q <= P6_LAT_RST;
      p8_dir_q <= P8_DIR_RST;
      p8_lat_q <= P8_LAT_RST;
      cfg_q    <= CFG_RST;
    end else begin
      p6_dir_q <= p6_dir_d;
      p6_lat_q <= p6_lat_d;
      p8_dir_q <= p8_dir_d;
      p8_lat_q <= p8_lat_d;
      cfg_q    <= cfg_d;
    end
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  always_comb begin
    rvalid_d  = (rvalid_q & ~rready) | ar_hs;
    arready_d = ~rvalid_d;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (ar_hs) begin
      rresp_d = RESP_OKAY;
      unique case (ridx)
        IDX_CFG:    rdata_d = {16'h0000, cfg_q};
        IDX_P6_DIR: rdata_d = {24'h000000, RD_ONES};
        IDX_P6_LAT: rdata_d = {24'h000000, p6_rd};
        IDX_P8_DIR: rdata_d = {24'h000000, RD_ONES};
        IDX_P7_PIN: rdata_d = {24'h000000, p7_in};
        IDX_P8_LAT: rdata_d = {24'h000000, p8_rd};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ------------------------------------------------------------
  // Pin functions
  // ------------------------------------------------------------
  always_comb begin
    p6_pad_d.oe[2]  = bre | p6_dir_q[2];
    p6_pad_d.out[2] = bre ? bus_grant_ack_n : p6_lat_q[2];
    p6_pad_d.oe[1]  = ~bre & p6_dir_q[1];
    p6_pad_d.out[1] = p6_lat_q[1];
    // Wait input keeps the driver off even if direction is misused
    p6_pad_d.oe[0]  = ~wait_sel & p6_dir_q[0];
    p6_pad_d.out[0] = p6_lat_q[0];
    p8_pad_d.oe     = p8_dir_q[4:0];
    p8_pad_d.out    = {chip_select_n[0], chip_select_n[1],
                       chip_select_n[2], chip_select_n[3],
                       p8_lat_q[0]};
    ctl_d.bus_request_n  = bre ? p6_in[1] : 1'b1;
    ctl_d.wait_request_n = wait_sel ? p6_in[0] : 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p6_pad_q <= '0;
      p8_pad_q <= '0;
      ctl_q    <= '1;
    end else begin
      p6_pad_q <= p6_pad_d;
      p8_pad_q <= p8_pad_d;
      ctl_q    <= ctl_d;
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign p6_pad  = p6_pad_q;
  assign p8_pad  = p8_pad_q;
  assign ctl     = ctl_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd(logic [15:0] idx);
    ar_hs && ridx == idx;
  endsequence

  sequence s_p8_lat_wr;
    do_wr && wstb_q && !hold && !hw_standby && widx_q == IDX_P8_LAT;
  endsequence

  property p_back;
    bre && !hw_standby |=> p6_pad.oe[2] && p6_pad.out[2] == $past(bus_grant_ack_n);
  endproperty
  a_back: assert property (p_back) else $error("ack pin not driven");

  property p_bus_request_n;
    bre |=> !p6_pad.oe[1] && ctl.bus_request_n == $past(p6_in[1]);
  endproperty
  a_bus_request_n: assert property (p_bus_request_n) else $error("request pin wrong");

  property p_wait;
    wait_sel |=> !p6_pad.oe[0] && ctl.wait_request_n == $past(p6_in[0]);
  endproperty
  a_wait: assert property (p_wait) else $error("wait pin wrong");

  property p_p7;
    s_rd(IDX_P7_PIN) |=> rvalid && rdata[7:0] == $past(p7_in);
  endproperty
  a_p7: assert property (p_p7) else $error("port 7 read wrong");

  property p_dir_ones;
    s_rd(IDX_P8_DIR) |=> rvalid && rdata == 32'h0000_00ff;
  endproperty
  a_dir_ones: assert property (p_dir_ones) else $error("dir read not ones");

  property p_p8_rd;
    s_rd(IDX_P8_LAT) |=> rdata[7:0] ==
      (8'he0 | ($past(p8_dir_q) & $past(p8_lat_q)) | (~$past(p8_dir_q) & {3'h0, $past(p8_in)}));
  endproperty
  a_p8_rd: assert property (p_p8_rd) else $error("port 8 read wrong");

  property p_p6_rd;
    s_rd(IDX_P6_LAT) |=> rdata[7:0] == {1'b1, $past(p6_lat_q[6:3]),
      ($past(p6_dir_q[2:0]) & $past(p6_lat_q[2:0])) | (~$past(p6_dir_q[2:0]) & $past(p6_in))};
  endproperty
  a_p6_rd: assert property (p_p6_rd) else $error("port 6 read wrong");

  property p_p8_wr;
    s_p8_lat_wr |=> p8_lat_q == ({3'h7, $past(wdat_q[4:0])}) ##1
      p8_pad.out[0] == $past(p8_lat_q[0]);
  endproperty
  a_p8_wr: assert property (p_p8_wr) else $error("port 8 write wrong");

  property p_p8_oe;
    1'b1 |=> p8_pad.oe == $past(p8_dir_q[4:0]);
  endproperty
  a_p8_oe: assert property (p_p8_oe) else $error("port 8 driver wrong");

  property p_standby;
    hw_standby |=> p8_dir_q == 8'hf0 && p8_lat_q == 8'he0;
  endproperty
  a_standby: assert property (p_standby) else $error("standby reset lost");

endmodule : psep_top

// File: psep_pkg.sv
// Constants and types for the port 6/7/8 pin logic
package psep_pkg;

  // ------------------------------------------------------------
  // Bus geometry and register indices (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam int          AW          = 18;
  localparam logic [15:0] IDX_CFG     = 16'hffc0;
  localparam logic [15:0] IDX_P6_DIR  = 16'hffc9;
  localparam logic [15:0] IDX_P6_LAT  = 16'hffcb;
  localparam logic [15:0] IDX_P8_DIR  = 16'hffcd;
  localparam logic [15:0] IDX_P7_PIN  = 16'hffce;
  localparam logic [15:0] IDX_P8_LAT  = 16'hffcf;

  // ------------------------------------------------------------
  // Reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0]  P6_DIR_RST  = 8'h80;
  localparam logic [7:0]  P6_LAT_RST  = 8'h80;
  localparam logic [7:0]  P8_DIR_RST  = 8'hf0;
  localparam logic [7:0]  P8_LAT_RST  = 8'he0;
  localparam logic [15:0] CFG_RST     = 16'hff00;
  localparam logic [7:0]  P6_DIR_WM   = 8'h07;
  localparam logic [7:0]  P6_LAT_WM   = 8'h7f;
  localparam logic [7:0]  P6_RSV      = 8'h80;
  localparam logic [7:0]  P8_WM       = 8'h1f;
  localparam logic [7:0]  P8_RSV      = 8'he0;
  localparam logic [7:0]  RD_ONES     = 8'hff;
  localparam logic [7:0]  WCE_ALL     = 8'hff;

  // ------------------------------------------------------------
  // Configuration register fields
  // ------------------------------------------------------------
  localparam int          CFG_BUS_RELEASE_ENABLE    = 0;
  localparam int          CFG_WMS     = 1;
  localparam int          CFG_WCE_LSB = 8;
  localparam int          CFG_W       = 16;

  // ------------------------------------------------------------
  // Bus responses
  // ------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } psep_p6_pad_s;

  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
  } psep_p8_pad_s;

  typedef struct packed {
    logic bus_request_n;
    logic wait_request_n;
  } psep_ctl_s;

endpackage : psep_pkg

// File: psep_pin_model.sv
// Pin-side partner model: far-side drivers and wire levels for ports 6, 7 and 8
`timescale 1ns/1ps

module psep_pin_model
  import psep_pkg::*;
(
  input  wire psep_p6_pad_s p6_pad,
  input  wire psep_p8_pad_s p8_pad,
  input  wire logic [2:0]   ext6,
  input  wire logic [7:0]   ext7,
  input  wire logic [4:0]   ext8,
  output      logic [2:0]   p6_in,
  output      logic [7:0]   p7_in,
  output      logic [4:0]   p8_in
);
  // ------------------------------------------------------------
  // Wire levels
  // ------------------------------------------------------------
  // Driven pins show the block's level, released pins the far side's
  assign p6_in = (p6_pad.oe & p6_pad.out) | (~p6_pad.oe & ext6);
  // Input-only pins, only the far side drives them
  assign p7_in = ext7;
  assign p8_in = (p8_pad.oe & p8_pad.out) | (~p8_pad.oe & ext8);
endmodule : psep_pin_model

// File: psep_top_test.sv
// Self-checking bench for the port 6/7/8 pin logic
`timescale 1ns/1ps

module psep_top_test import psep_pkg::*;;
  logic          aclk, aresetn, hw_standby, sw_standby;
  logic          awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0]   wdata, rdata;
  logic [3:0]    wstrb, chip_select_n;
  logic [3:0]    wmask;
  logic [1:0]    bresp, rresp;
  logic [2:0]    p6_in, ext6;
  logic [7:0]    p7_in, ext7;
  logic [4:0]    p8_in, ext8;
  logic          bus_grant_ack_n;
  psep_p6_pad_s  p6_pad;
  psep_p8_pad_s  p8_pad;
  psep_ctl_s     ctl;
  int            err_total, checked;
  logic [15:0]   cfg_tab [4] = '{16'hff01, 16'h0000, 16'hff02, 16'hff00};
  logic [1:0]    ctl_tab [4] = '{2'b01, 2'b10, 2'b10, 2'b11};
  logic [2:0]    oe_tab  [4] = '{3'b100, 3'b000, 3'b000, 3'b000};

  // ------------------------------------------------------------
  // Design and pin model
  // ------------------------------------------------------------
  psep_top i_dut (
    .aclk, .aresetn, .hw_standby, .sw_standby, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .p6_in, .p6_pad, .p7_in, .p8_in, .p8_pad, .bus_grant_ack_n, .chip_select_n, .ctl
  );
  psep_pin_model i_pins (.p6_pad, .p8_pad, .ext6, .ext7, .ext8, .p6_in, .p7_in, .p8_in);

  always #12.5 aclk = ~aclk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic guard(input int n);
    if (n >= 64) begin
      err_total++;
      tally_and_finish();
    end
  endtask : guard

  task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr  <= {idx, 2'b00};
    wdata   <= {16'h0000, d};
    wstrb   <= wmask;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    bready <= 1'b0;
    guard(n);
    chk(32'(bresp), 32'(er));
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    rready <= 1'b0;
    guard(n);
    chk(rdata, {24'h000000, ed});
    chk(32'(rresp), 32'(er));
    @(posedge aclk);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask : settle

  task automatic pad8(input logic [4:0] oe, input logic [4:0] dv);
    chk(32'({p8_pad.oe, p8_pad.out & p8_pad.oe}), 32'({oe, dv}));
  endtask : pad8

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    err_total = 0;
    checked = 0;
    wmask = 4'hf;
    aclk = 1'b0;
    aresetn <= 1'b0;
    {hw_standby, sw_standby, awvalid, wvalid, bready, arvalid, rready} <= '0;
    awaddr <= '0;
    araddr <= '0;
    wdata <= '0;
    wstrb <= '0;
    bus_grant_ack_n <= 1'b1;
    chip_select_n <= 4'b0101;
    ext6 <= 3'b100;
    ext7 <= 8'h5a;
    ext8 <= 5'h0a;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset state and port 7 pin reads
    rd(IDX_P8_DIR, 8'hff, RESP_OKAY);
    rd(IDX_P8_LAT, 8'hea, RESP_OKAY);
    pad8(5'h10, 5'h10);
    rd(IDX_P7_PIN, 8'h5a, RESP_OKAY);
    ext7 <= 8'ha5;
    rd(IDX_P7_PIN, 8'ha5, RESP_OKAY);
    // Port 8 plain output and chip selects
    wr(IDX_P8_LAT, 16'h0015, RESP_OKAY);
    wr(IDX_P8_DIR, 16'h0001, RESP_OKAY);
    settle();
    pad8(5'h01, 5'h01);
    rd(IDX_P8_LAT, 8'heb, RESP_OKAY);
    wr(IDX_P8_DIR, 16'h001f, RESP_OKAY);
    settle();
    pad8(5'h1f, 5'h15);
    rd(IDX_P8_LAT, 8'hf5, RESP_OKAY);
    // Low strobe clear, write ignored
    wmask = 4'he;
    wr(IDX_P8_LAT, 16'h0000, RESP_OKAY);
    wmask = 4'hf;
    rd(IDX_P8_LAT, 8'hf5, RESP_OKAY);
    // Software standby holds port 8 direction and latch
    sw_standby <= 1'b1;
    wr(IDX_P8_DIR, 16'h0000, RESP_OKAY);
    wr(IDX_P8_LAT, 16'h0000, RESP_OKAY);
    sw_standby <= 1'b0;
    settle();
    pad8(5'h1f, 5'h15);
    rd(IDX_P8_LAT, 8'hf5, RESP_OKAY);
    // Hardware standby reloads
    hw_standby <= 1'b1;
    repeat (2) @(posedge aclk);
    hw_standby <= 1'b0;
    settle();
    pad8(5'h10, 5'h10);
    rd(IDX_P8_LAT, 8'hea, RESP_OKAY);
    // Port 6 plain function
    wr(IDX_P6_DIR, 16'h0007, RESP_OKAY);
    wr(IDX_P6_LAT, 16'h0005, RESP_OKAY);
    settle();
    chk(32'({p6_pad.oe, p6_pad.out & p6_pad.oe}), 32'({3'b111, 3'b101}));
    rd(IDX_P6_LAT, 8'h85, RESP_OKAY);
    rd(IDX_P6_DIR, 8'hff, RESP_OKAY);
    wr(IDX_P6_DIR, 16'h0000, RESP_OKAY);
    settle();
    rd(IDX_P6_LAT, 8'h84, RESP_OKAY);
    // Alternate functions across four selector settings
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CFG, cfg_tab[i], RESP_OKAY);
      settle();
      chk(32'({ctl, p6_pad.oe, p6_pad.out & p6_pad.oe}),
          32'({ctl_tab[i], oe_tab[i], oe_tab[i]}));
    end
    wr(IDX_CFG, 16'hff01, RESP_OKAY);
    bus_grant_ack_n <= 1'b0;
    settle();
    chk(32'({p6_pad.oe, p6_pad.out[2]}), 32'(4'b1000));
    // Unmapped place
    rd(16'hffc1, 8'h00, RESP_SLVERR);
    wr(16'hffc1, 16'h00ff, RESP_SLVERR);
    tally_and_finish();
  end
endmodule : psep_top_test
